// [rtl/tsdr_pkg.sv]
// Package for the tile status and debug register bank: map, fields and carriers
// Contract
// - Four free-running ring oscillators each drive a counter; software starts and stops them.
// - Control bit 1 enables tile oscillators, bit 0 peripheral ones; both reset to 0.
// - Oscillators run unrelated to the tile clock; counts may serve as random bits.
// - Four read-only counter registers show the count in 15:0, upper half zero.
// - System reset leaves the oscillator counts untouched.
// - Counters map to tile cell, tile wire, peripheral cell, peripheral wire.
// - Read-only memory size register gives RAM bytes in 31:2, bits 1:0 zero.
// - Debug entry captures saved status; bit 10 space id, 9 entry issue, 8 issue copy.
// - Status bits: 7 fast issue, 6 paused, 4 kernel, 3 in interrupt, 2 enabling.
// - Status bit 1 means interrupts enabled, bit 0 means events enabled.
// - Debug entry captures saved PC and SP, full words, writable in debug mode.
// - Register-read operands hold thread number 7:0 and register number 4:0.
// - Cause field 2:0 resets to 0: host, debug call, ibreak, data, resource watch.
// - Bits 15:8 give causing thread number; zero for host requests.
// - Data watch captures effective address; resource watch captures resource id.
// - Threads set in the 8-bit stop mask do not run outside debug mode.
// - Eight scratch words shared between status access and tile configuration access.
// - Four breakpoint addresses; a match on an enabled one requests a debug interrupt.
// - Breakpoint control: thread enables 23:16, condition bit 1, enable bit 0, reset 0.
package tsdr_pkg;

    // ------------------------------------------------------------------
    // Register offsets (status register numbers)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_RING_CTRL    = 8'h06;
    localparam logic [7:0] OFS_RING_COUNT0  = 8'h07;
    localparam logic [7:0] OFS_MEM_SIZE     = 8'h0C;
    localparam logic [7:0] OFS_DBG_STATUS   = 8'h10;
    localparam logic [7:0] OFS_DBG_PC       = 8'h11;
    localparam logic [7:0] OFS_DBG_SP       = 8'h12;
    localparam logic [7:0] OFS_DBG_RD_THR   = 8'h13;
    localparam logic [7:0] OFS_DBG_RD_REG   = 8'h14;
    localparam logic [7:0] OFS_DBG_CAUSE    = 8'h15;
    localparam logic [7:0] OFS_DBG_DATA     = 8'h16;
    localparam logic [7:0] OFS_DBG_STOP     = 8'h18;
    localparam logic [7:0] OFS_SCRATCH0     = 8'h20;
    localparam logic [7:0] OFS_IBRK_ADDR0   = 8'h30;
    localparam logic [7:0] OFS_IBRK_CTRL0   = 8'h40;

    // ------------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------------
    localparam int          BIT_RING_TILE_EN   = 1;
    localparam int          BIT_RING_PERIPH_EN = 0;
    localparam logic [31:0] MASK_STATUS_WR     = 32'h0000_06DF;
    localparam logic [31:0] MASK_STATUS_CAP    = 32'h0000_07DF;
    localparam logic [31:0] MASK_CAUSE         = 32'h0003_FF07;
    localparam logic [31:0] MASK_IBRK_CTRL     = 32'h00FF_0003;
    localparam logic [31:0] MASK_MEM_SIZE      = 32'hFFFF_FFFC;
    localparam int          BIT_IBRK_EN        = 0;
    localparam int          BIT_IBRK_NE        = 1;
    localparam int          POS_IBRK_THREADS   = 16;
    localparam int          POS_CAUSE_THREAD   = 8;
    localparam int          POS_CAUSE_NUM      = 16;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [1:0]  RST_RING_CTRL   = 2'h0;
    localparam logic [2:0]  RST_CAUSE       = 3'h0;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [15:0] RST_RING_COUNT  = 16'h0000;
    localparam int          RING_SETTLE_CYC = 10;

    // Debug cause codes
    localparam logic [2:0] CAUSE_HOST  = 3'h1;
    localparam logic [2:0] CAUSE_DEBUG_CALL_INSTR = 3'h2;
    localparam logic [2:0] CAUSE_IBRK  = 3'h3;
    localparam logic [2:0] CAUSE_DWAT  = 3'h4;
    localparam logic [2:0] CAUSE_RWAT  = 3'h5;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } tsdr_ps_req_s;

    typedef struct packed {
        logic        valid;
        logic [2:0]  cause;
        logic [7:0]  thread;
        logic [3:0]  hits;
        logic [31:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] data;
    } tsdr_dbg_entry_s;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] pc;
    } tsdr_pc_probe_s;

endpackage

// [rtl/tsdr_regs.sv]
// Tile status and debug register bank with ring counters and breakpoint compare
`timescale 1ns/1ps
module tsdr_regs
    import tsdr_pkg::*;
#(
    parameter logic [31:0] MEM_SIZE_BYTES = 32'h0008_0000
)(
    input  wire logic            clk_sys,
    input  wire logic            srst,
    input  wire logic            pwr_on_rst,
    input  wire tsdr_ps_req_s    ps_req,
    output logic [31:0]          ps_rdata_ff,
    input  wire logic            debug_mode,
    input  wire tsdr_dbg_entry_s dbg_entry,
    input  wire logic            cfg_wr,
    input  wire logic            cfg_rd,
    input  wire logic [2:0]      cfg_idx,
    input  wire logic [31:0]     cfg_wdata,
    output logic [31:0]          cfg_rdata_ff,
    input  wire logic [3:0]      ring_osc_in,
    input  wire tsdr_pc_probe_s  pc_probe,
    output logic                 ibrk_req_ff,
    output logic [1:0]           ibrk_num_ff,
    output logic [7:0]           thread_stop_ff,
    output logic [1:0]           ring_enable_ff
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lowest number wins on a tie
    function automatic logic [1:0] lowest_set(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // Address within a block of cnt registers
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                      input logic [7:0] cnt);
        return (a >= base) && (a < 8'(base + cnt));
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [1:0]  ring_ctrl_ff;
    logic [15:0] ring_count_ff [4];
    logic [3:0]  ring_last_ff;

    logic [31:0] dbg_status_ff;
    logic [31:0] dbg_pc_ff;
    logic [31:0] dbg_sp_ff;

    logic [7:0]  rd_thread_ff;
    logic [4:0]  rd_reg_ff;

    logic [2:0]  cause_type_ff;
    logic [7:0]  cause_thread_ff;
    logic [1:0]  cause_num_ff;

    logic [31:0] dbg_data_ff;
    logic [7:0]  stop_mask_ff;

    logic [31:0] scratch_ff   [8];

    logic [31:0] ibrk_addr_ff [4];
    logic [31:0] ibrk_ctrl_ff [4];

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // Debug registers only accept writes from code running in debug mode
    wire         wr_any      = ps_req.wr;
    wire         wr_dbg      = ps_req.wr && debug_mode;

    wire  [7:0]  wa          = ps_req.addr;
    wire  [31:0] wd          = ps_req.wdata;

    wire         wr_ring     = wr_any && (wa == OFS_RING_CTRL);

    wire         wr_status   = wr_dbg && (wa == OFS_DBG_STATUS);
    wire         wr_pc       = wr_dbg && (wa == OFS_DBG_PC);
    wire         wr_sp       = wr_dbg && (wa == OFS_DBG_SP);
    wire         wr_rd_thr   = wr_dbg && (wa == OFS_DBG_RD_THR);
    wire         wr_rd_reg   = wr_dbg && (wa == OFS_DBG_RD_REG);
    wire         wr_cause    = wr_dbg && (wa == OFS_DBG_CAUSE);
    wire         wr_data     = wr_dbg && (wa == OFS_DBG_DATA);
    wire         wr_stop     = wr_dbg && (wa == OFS_DBG_STOP);

    wire         wr_scr_ps   = wr_dbg && in_range(wa, OFS_SCRATCH0, 8'h08);
    wire         wr_ia       = wr_dbg && in_range(wa, OFS_IBRK_ADDR0, 8'h04);
    wire         wr_ic       = wr_dbg && in_range(wa, OFS_IBRK_CTRL0, 8'h04);

    wire  [2:0]  scr_ps_idx  = 3'(wa - OFS_SCRATCH0);
    wire  [1:0]  ia_idx      = 2'(wa - OFS_IBRK_ADDR0);
    wire  [1:0]  ic_idx      = 2'(wa - OFS_IBRK_CTRL0);

    // Capture of debug entry takes priority over a software write in the same cycle
    wire         cap         = dbg_entry.valid;

    wire         cap_host    = dbg_entry.cause == CAUSE_HOST;
    wire         cap_numbered = (dbg_entry.cause == CAUSE_IBRK) ||
                               (dbg_entry.cause == CAUSE_DWAT) ||
                               (dbg_entry.cause == CAUSE_RWAT);
    wire         cap_data    = (dbg_entry.cause == CAUSE_DWAT) ||
                               (dbg_entry.cause == CAUSE_RWAT);

    // ------------------------------------------------------------------
    // Ring oscillator counters
    // ------------------------------------------------------------------
    // Each oscillator line is counted on its rising edge; counters 0,1 belong to the
    // tile domain and 2,3 to the peripheral domain
    wire  [3:0]  ring_run    = {{2{ring_ctrl_ff[BIT_RING_PERIPH_EN]}},
                                {2{ring_ctrl_ff[BIT_RING_TILE_EN]}}};
    wire  [3:0]  ring_edge   = ring_osc_in & ~ring_last_ff & ring_run;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ring_ctrl_ff <= RST_RING_CTRL;
        end else if (wr_ring) begin
            ring_ctrl_ff <= {wd[BIT_RING_TILE_EN], wd[BIT_RING_PERIPH_EN]};
        end
    end

    // Counts survive system reset; only power-on clears them
    // Counts wrap at 16 bits; take differences
    always_ff @(posedge clk_sys) begin
        ring_last_ff <= ring_osc_in;
        for (int i = 0; i < 4; i++) begin
            if (pwr_on_rst) begin
                ring_count_ff[i] <= RST_RING_COUNT;
            end else if (ring_edge[i]) begin
                ring_count_ff[i] <= 16'(ring_count_ff[i] + 16'h0001);
            end
        end
    end

    // ------------------------------------------------------------------
    // Captured debug state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dbg_status_ff <= RST_WORD;
        end else if (cap) begin
            dbg_status_ff <= dbg_entry.status & MASK_STATUS_CAP;
        end else if (wr_status) begin
            // The issue-mode copy in bit 8 stays read-only
            dbg_status_ff <= (wd & MASK_STATUS_WR) |
                             (dbg_status_ff & ~MASK_STATUS_WR);
        end
    end

    // Debugger may patch these before return
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dbg_pc_ff <= RST_WORD;
            dbg_sp_ff <= RST_WORD;
        end else begin
            if (cap) begin
                dbg_pc_ff <= dbg_entry.pc;
                dbg_sp_ff <= dbg_entry.sp;
            end else begin
                if (wr_pc) begin
                    dbg_pc_ff <= wd;
                end
                if (wr_sp) begin
                    dbg_sp_ff <= wd;
                end
            end
        end
    end

    // Operand fields keep only their low bits
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_thread_ff <= 8'h00;
            rd_reg_ff    <= 5'h00;
        end else begin
            if (wr_rd_thr) begin
                rd_thread_ff <= wd[7:0];
            end
            if (wr_rd_reg) begin
                rd_reg_ff <= wd[4:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cause_type_ff   <= RST_CAUSE;
            cause_thread_ff <= 8'h00;
            cause_num_ff    <= 2'h0;
        end else if (cap) begin
            cause_type_ff   <= dbg_entry.cause;
            cause_thread_ff <= cap_host ? 8'h00 : dbg_entry.thread;
            cause_num_ff    <= cap_numbered ? lowest_set(dbg_entry.hits)
                                            : 2'h0;
        end else if (wr_cause) begin
            cause_type_ff   <= wd[2:0];
            cause_thread_ff <= wd[POS_CAUSE_THREAD +: 8];
            cause_num_ff    <= wd[POS_CAUSE_NUM +: 2];
        end
    end

    // Other causes leave the data word as it was
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dbg_data_ff <= RST_WORD;
        end else if (cap && cap_data) begin
            dbg_data_ff <= dbg_entry.data;
        end else if (wr_data) begin
            dbg_data_ff <= wd;
        end
    end

    // Applied only once debug mode is left
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stop_mask_ff <= 8'h00;
        end else if (wr_stop) begin
            stop_mask_ff <= wd[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Scratch words, reachable from both access paths
    // ------------------------------------------------------------------
    // A status write wins over a configuration write to the same word
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (srst) begin
                scratch_ff[i] <= RST_WORD;
            end else if (wr_scr_ps && (scr_ps_idx == 3'(i))) begin
                scratch_ff[i] <= wd;
            end else if (cfg_wr && (cfg_idx == 3'(i))) begin
                scratch_ff[i] <= cfg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Instruction breakpoints
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (srst) begin
                ibrk_addr_ff[i] <= RST_WORD;
                ibrk_ctrl_ff[i] <= RST_WORD;
            end else begin
                if (wr_ia && (ia_idx == 2'(i))) begin
                    ibrk_addr_ff[i] <= wd;
                end
                if (wr_ic && (ic_idx == 2'(i))) begin
                    ibrk_ctrl_ff[i] <= wd & MASK_IBRK_CTRL;
                end
            end
        end
    end

    // Not-equal mode inverts the compare
    logic [3:0] ibrk_hit;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ibrk_hit[i] = pc_probe.valid && ibrk_ctrl_ff[i][BIT_IBRK_EN] &&
                          ibrk_ctrl_ff[i][POS_IBRK_THREADS + int'(pc_probe.thread)] &&
                          ((pc_probe.pc == ibrk_addr_ff[i]) ^
                           ibrk_ctrl_ff[i][BIT_IBRK_NE]);
        end
    end

    // Breakpoints are ignored while already in debug mode, so the handler cannot
    // re-trigger itself
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ibrk_req_ff <= 1'b0;
            ibrk_num_ff <= 2'h0;
        end else begin
            ibrk_req_ff <= (|ibrk_hit) && !debug_mode;
            ibrk_num_ff <= lowest_set(ibrk_hit);
        end
    end

    // All threads run freely in debug mode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            thread_stop_ff <= 8'h00;
        end else begin
            thread_stop_ff <= debug_mode ? 8'h00 : stop_mask_ff;
        end
    end

    // Enables as seen by the oscillator cells
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ring_enable_ff <= RST_RING_CTRL;
        end else begin
            ring_enable_ff <= ring_ctrl_ff;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire  [7:0]  ra        = ps_req.addr;

    wire  [2:0]  ra_ring   = 3'(ra - OFS_RING_COUNT0);
    wire  [2:0]  ra_scr    = 3'(ra - OFS_SCRATCH0);
    wire  [1:0]  ra_ia     = 2'(ra - OFS_IBRK_ADDR0);
    wire  [1:0]  ra_ic     = 2'(ra - OFS_IBRK_CTRL0);

    wire  [31:0] cause_word = {14'h0000, cause_num_ff, cause_thread_ff,
                               5'h00, cause_type_ff};

    // Unmapped numbers read as zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = RST_WORD;
        if (ra == OFS_RING_CTRL) begin
            rd_word = {30'h0, ring_ctrl_ff};
        end else if (in_range(ra, OFS_RING_COUNT0, 8'h04)) begin
            rd_word = {16'h0000, ring_count_ff[ra_ring[1:0]]};
        end else if (ra == OFS_MEM_SIZE) begin
            rd_word = MEM_SIZE_BYTES & MASK_MEM_SIZE;
        end else if (ra == OFS_DBG_STATUS) begin
            rd_word = dbg_status_ff;
        end else if (ra == OFS_DBG_PC) begin
            rd_word = dbg_pc_ff;
        end else if (ra == OFS_DBG_SP) begin
            rd_word = dbg_sp_ff;
        end else if (ra == OFS_DBG_RD_THR) begin
            rd_word = {24'h0, rd_thread_ff};
        end else if (ra == OFS_DBG_RD_REG) begin
            rd_word = {27'h0, rd_reg_ff};
        end else if (ra == OFS_DBG_CAUSE) begin
            rd_word = cause_word & MASK_CAUSE;
        end else if (ra == OFS_DBG_DATA) begin
            rd_word = dbg_data_ff;
        end else if (ra == OFS_DBG_STOP) begin
            rd_word = {24'h0, stop_mask_ff};
        end else if (in_range(ra, OFS_SCRATCH0, 8'h08)) begin
            rd_word = scratch_ff[ra_scr];
        end else if (in_range(ra, OFS_IBRK_ADDR0, 8'h04)) begin
            rd_word = ibrk_addr_ff[ra_ia];
        end else if (in_range(ra, OFS_IBRK_CTRL0, 8'h04)) begin
            rd_word = ibrk_ctrl_ff[ra_ic];
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ps_rdata_ff <= RST_WORD;
        end else if (ps_req.rd) begin
            ps_rdata_ff <= rd_word;
        end
    end

    // Same words as the status path sees
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_rdata_ff <= RST_WORD;
        end else if (cfg_rd) begin
            cfg_rdata_ff <= scratch_ff[cfg_idx];
        end
    end

endmodule

// [test/tsdr_regs_properties.sv]
// Port-level assertions for the tile status and debug register bank
`timescale 1ns/1ps
module tsdr_regs_properties
    import tsdr_pkg::*;
#(
    parameter logic [31:0] MEM_SIZE_BYTES = 32'h0008_0000
)(
    input wire logic            clk_sys,
    input wire logic            srst,
    input wire tsdr_ps_req_s    ps_req,
    input wire logic [31:0]     ps_rdata_ff,
    input wire logic            debug_mode,
    input wire tsdr_dbg_entry_s dbg_entry,
    input wire tsdr_pc_probe_s  pc_probe,
    input wire logic            ibrk_req_ff,
    input wire logic [7:0]      thread_stop_ff,
    input wire logic [1:0]      ring_enable_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic       wr_ctrl = ps_req.wr && ps_req.addr == OFS_RING_CTRL;
    wire logic [7:0] ra      = ps_req.addr;
    // Reset itself is the antecedent here, so the default disable is overridden
    rst_clear_a: assert property (disable iff (1'b0) srst |=>
        !ibrk_req_ff && thread_stop_ff == 8'h00 && ring_enable_ff == 2'b00) else $error("no reset");
    ring_en_a: assert property ($past(wr_ctrl, 2) && !$past(wr_ctrl) && !$past(srst)
        && !$past(srst, 2) |-> ring_enable_ff == $past(ps_req.wdata[1:0], 2)) else $error("ring en");
    stop_dbg_a: assert property (debug_mode |=> thread_stop_ff == 8'h00)
        else $error("stop mask in debug");
    ibrk_dbg_a: assert property (debug_mode |=> !ibrk_req_ff)
        else $error("break in debug");
    ibrk_src_a: assert property (ibrk_req_ff |-> $past(pc_probe.valid) && !$past(debug_mode))
        else $error("break without probe");
    cnt_upper_a: assert property (ps_req.rd && ra inside {[8'h07:8'h0A]} |=>
        ps_rdata_ff[31:16] == 16'h0000) else $error("count upper bits");
    mem_size_a: assert property (ps_req.rd && ra == OFS_MEM_SIZE |=>
        ps_rdata_ff == (MEM_SIZE_BYTES & MASK_MEM_SIZE)) else $error("memory size");
    unmapped_read_a: assert property (ps_req.rd && ra == 8'h0B |=>
        ps_rdata_ff == 32'h0) else $error("unmapped read");
    host_cause_a: assert property (dbg_entry.valid && dbg_entry.cause == CAUSE_HOST
        ##1 ps_req.rd && ra == OFS_DBG_CAUSE |=> ps_rdata_ff == 32'h1) else $error("host cause");
    cover property (wr_ctrl);
    cover property (ibrk_req_ff);
    cover property (dbg_entry.valid && dbg_entry.cause == CAUSE_RWAT);
endmodule

bind tsdr_regs tsdr_regs_properties #(.MEM_SIZE_BYTES(MEM_SIZE_BYTES)) i_tsdr_regs_properties (
    .clk_sys, .srst, .ps_req, .ps_rdata_ff, .debug_mode, .dbg_entry, .pc_probe,
    .ibrk_req_ff, .thread_stop_ff, .ring_enable_ff);

// [test/tsdr_ring_src.sv]
// Free-running ring oscillator lines feeding the register bank
`timescale 1ns/1ps
module tsdr_ring_src (
    input  wire logic       clk_sys,
    output logic      [3:0] ring_osc_in
);
    // Line i rises every 2**(i+1) cycles, so a swapped mapping shows in the counts
    logic [3:0] phase_ff = 4'h0;
    always_ff @(posedge clk_sys) begin
        phase_ff <= phase_ff + 4'h1;
    end
    assign ring_osc_in = phase_ff;
endmodule

// [test/tsdr_regs_tb.sv]
// Self-checking bench for the tile status and debug register bank
`timescale 1ns/1ps
module tsdr_regs_tb
    import tsdr_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;
        logic        dbg;
        logic [31:0] wdata;
        logic [31:0] exp;
    } tsdr_row_s;
    logic            clk_sys = 1'b0;
    logic            srst = 1'b1;
    logic            pwr_on_rst = 1'b1;
    logic            debug_mode = 1'b0;
    logic            cfg_wr = 1'b0;
    logic            cfg_rd = 1'b0;
    logic [2:0]      cfg_idx = 3'h0;
    logic [31:0]     cfg_wdata = 32'h0;
    tsdr_ps_req_s    ps_req = '0;
    tsdr_dbg_entry_s dbg_entry = '0;
    tsdr_pc_probe_s  pc_probe = '0;
    logic [31:0]     ps_rdata_ff, cfg_rdata_ff, q, prev, c[4];
    logic [3:0]      ring_osc_in;
    logic            ibrk_req_ff;
    logic [1:0]      ibrk_num_ff, ring_enable_ff, nm;
    logic [7:0]      thread_stop_ff;
    int              mismatches = 0;
    int              tests_run = 0;
    tsdr_row_s       rows[15];
    // Low bits set on purpose: the read must mask them off
    tsdr_regs #(.MEM_SIZE_BYTES(32'h0004_0003)) i_tsdr_regs (.clk_sys, .srst, .pwr_on_rst,
        .ps_req, .ps_rdata_ff, .debug_mode, .dbg_entry, .cfg_wr, .cfg_rd, .cfg_idx, .cfg_wdata,
        .cfg_rdata_ff, .ring_osc_in, .pc_probe, .ibrk_req_ff, .ibrk_num_ff, .thread_stop_ff,
        .ring_enable_ff);
    tsdr_ring_src i_tsdr_ring_src (.clk_sys, .ring_osc_in);
    initial forever #20 clk_sys = ~clk_sys;
    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ps(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        ps_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_sys);
        ps_req <= '0;
        #1 q = ps_rdata_ff;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        ps(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic probe(input logic [2:0] t, input logic [31:0] p, input logic [2:0] e);
        @(posedge clk_sys);
        pc_probe <= '{1'b1, t, p};
        @(posedge clk_sys);
        pc_probe <= '0;
        #1 chk("break", {29'h0, e}, {29'h0, ibrk_req_ff, ibrk_req_ff ? ibrk_num_ff : 2'b00});
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        conclude();
    end
    initial begin
        rows = '{'{8'h06, 1'b0, 32'hFFFF_FFFD, 32'h0000_0001},
            '{8'h10, 1'b1, 32'hFFFF_FFFF, 32'h0000_06DF},
            '{8'h11, 1'b1, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
            '{8'h12, 1'b1, 32'h1234_5678, 32'h1234_5678},
            '{8'h13, 1'b1, 32'hFFFF_FFFF, 32'h0000_00FF},
            '{8'h14, 1'b1, 32'hFFFF_FFFF, 32'h0000_001F},
            '{8'h15, 1'b1, 32'hFFFF_FFFF, 32'h0003_FF07},
            '{8'h16, 1'b1, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
            '{8'h18, 1'b1, 32'hFFFF_FFFF, 32'h0000_00FF},
            '{8'h27, 1'b1, 32'hCAFE_F00D, 32'hCAFE_F00D},
            '{8'h33, 1'b1, 32'h8765_4321, 32'h8765_4321},
            '{8'h43, 1'b1, 32'hFFFE_FFFE, 32'h00FE_0002},
            '{8'h11, 1'b0, 32'h0000_0000, 32'hA5A5_5A5A},
            '{8'h0C, 1'b1, 32'hFFFF_FFFF, 32'h0004_0000},
            '{8'h0B, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000}};
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        pwr_on_rst <= 1'b0;
        for (int i = 0; i < 4; i++) rc(OFS_RING_COUNT0 + 8'(i), 32'h0);
        foreach (rows[i]) begin
            @(posedge clk_sys) debug_mode <= rows[i].dbg;
            ps(1'b1, rows[i].addr, rows[i].wdata);
            rc(rows[i].addr, rows[i].exp);
        end
        chk("stop mask", 32'h0, {24'h0, thread_stop_ff});
        prev = 32'hDEAD_BEEF;
        for (int k = 1; k <= 5; k++) begin
            @(posedge clk_sys);
            dbg_entry <= '{1'b1, 3'(k), 8'h07, 4'hC, 32'hFFFF_FFFF, 32'h100 + k, ~k, 32'h5000 + k};
            @(posedge clk_sys);
            dbg_entry <= '0;
            ps_req <= '{wr: 1'b0, rd: 1'b1, addr: OFS_DBG_CAUSE, wdata: 32'h0};
            @(posedge clk_sys);
            ps_req <= '0;
            #1 nm = (k >= 3) ? 2'd2 : 2'd0;
            chk("cause", {14'h0, nm, (k == 1) ? 8'h00 : 8'h07, 5'h0, 3'(k)}, ps_rdata_ff);
            if (k >= 4) prev = 32'h5000 + k;
            rc(OFS_DBG_DATA, prev);
        end
        rc(OFS_DBG_STATUS, 32'h0000_07DF);
        rc(OFS_DBG_PC, 32'h0000_0105);
        rc(OFS_DBG_SP, 32'hFFFF_FFFA);
        ps(1'b1, OFS_RING_CTRL, 32'h2);
        ps(1'b1, OFS_IBRK_ADDR0, 32'h100);
        ps(1'b1, OFS_IBRK_ADDR0 + 8'h1, 32'h100);
        ps(1'b1, OFS_IBRK_CTRL0, 32'h0004_0001);
        ps(1'b1, OFS_IBRK_CTRL0 + 8'h1, 32'h0004_0001);
        probe(3'd2, 32'h100, 3'b000);
        @(posedge clk_sys) debug_mode <= 1'b0;
        probe(3'd2, 32'h100, 3'b100);
        chk("stop mask", 32'hFF, {24'h0, thread_stop_ff});
        probe(3'd3, 32'h100, 3'b000);
        @(posedge clk_sys) debug_mode <= 1'b1;
        ps(1'b1, OFS_IBRK_CTRL0, 32'h0004_0003);
        @(posedge clk_sys) debug_mode <= 1'b0;
        probe(3'd2, 32'h100, 3'b101);
        probe(3'd2, 32'h104, 3'b100);
        @(posedge clk_sys) {cfg_rd, cfg_idx} <= 4'hF;
        @(posedge clk_sys) cfg_rd <= 1'b0;
        #1 chk("cfg scratch", 32'hCAFE_F00D, cfg_rdata_ff);
        @(posedge clk_sys) {cfg_wr, cfg_idx, cfg_wdata} <= {1'b1, 3'h0, 32'h0BAD_C0DE};
        @(posedge clk_sys) cfg_wr <= 1'b0;
        rc(OFS_SCRATCH0, 32'h0BAD_C0DE);
        ps(1'b1, OFS_RING_CTRL, 32'h0);
        repeat (RING_SETTLE_CYC) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            ps(1'b0, OFS_RING_COUNT0 + 8'(i), 32'h0);
            c[i] = q;
        end
        chk("tile counts", 32'h1, {31'h0, c[0] > c[1] && c[1] != 0});
        chk("periph counts", 32'h1, {31'h0, c[2] > c[3] && c[3] != 0});
        ps(1'b1, OFS_RING_CTRL, 32'h1);
        @(posedge clk_sys) srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        rc(OFS_RING_COUNT0, c[0]);
        rc(OFS_RING_CTRL, 32'h0);
        rc(OFS_DBG_CAUSE, 32'h0);
        rc(OFS_IBRK_CTRL0, 32'h0);
        conclude();
    end
endmodule
